// >>> core/eltx_pkg.sv
package eltx_pkg;
  // Core timing
  localparam int CORE_MHZ        = 250;
  localparam int LINK_HALF_CYC   = 20;
  localparam int LINK_QTR_CYC    = LINK_HALF_CYC / 2;
  localparam int STOP_MIN_EDGES  = 9;

  // Line timing, in microseconds or milliseconds as named
  localparam int WAKE_1000_US    = 16;
  localparam int WAKE_100_US     = 30;
  localparam int REFRESH_US      = 210;
  localparam int REFRESH_PER_US  = 21000;
  localparam int LINKUP_WAIT_MS  = 1000;
  // Longest times convert exactly to whole cycles
  localparam int WAKE_1000_CYC   = WAKE_1000_US * CORE_MHZ;
  localparam int WAKE_100_CYC    = WAKE_100_US * CORE_MHZ;
  localparam int REFRESH_CYC     = REFRESH_US * CORE_MHZ;
  localparam int QUIET_CYC       = (REFRESH_PER_US - REFRESH_US) * CORE_MHZ;
  localparam int LINKUP_WAIT_CYC = LINKUP_WAIT_MS * 1000 * CORE_MHZ;

  // Device management map
  localparam logic [7:0] BASIC_CTRL_OFS = 8'h00;
  localparam logic [7:0] WAIT_CFG_OFS   = 8'h10;
  localparam logic [7:0] DEV_STAT_OFS   = 8'h11;
  localparam logic [7:0] ADV_OFS        = 8'h3c;
  localparam int ADV_100_BIT     = 1;
  localparam int ADV_1000_BIT    = 2;
  localparam int RESTART_AN_BIT  = 9;
  localparam int WAIT_EN_BIT     = 0;
  localparam logic WAIT_EN_RST   = 1'b1;
  // Device status bits
  localparam int ST_TX_LPI = 0;
  localparam int ST_RX_LPI = 1;
  localparam int ST_CAP    = 2;
  localparam int ST_WAITED = 3;
  localparam int ST_ACT100 = 4;
  localparam int ST_ACT1G  = 5;

  // Controller APB map
  localparam logic [11:0] H_CTRL_OFS = 12'h000;
  localparam logic [11:0] H_STAT_OFS = 12'h004;
  localparam int HC_LPI_REQ = 0;
  localparam int HC_MODE_LO = 1;
  localparam int HC_STOP_EN = 3;
  localparam int HS_LPI     = 0;
  localparam int HS_STOPPED = 1;
  localparam int HS_CAP     = 2;

  // Low-power idle encoding: enable low, error high, data 0000_0001
  localparam logic [7:0] LPI_DATA = 8'h01;

  typedef enum logic [1:0] {
    ELTX_GMII      = 2'h0,
    ELTX_MII       = 2'h1,
    ELTX_RGMII_1G  = 2'h2,
    ELTX_RGMII_100 = 2'h3
  } eltx_mode_t;

  typedef enum logic [3:0] {
    LN_ACTIVE  = 4'h1,
    LN_QUIET   = 4'h2,
    LN_REFRESH = 4'h4,
    LN_WAKE    = 4'h8
  } eltx_line_t;

  typedef enum logic [2:0] {
    HT_IDLE    = 3'h1,
    HT_LPI     = 3'h2,
    HT_STOPPED = 3'h4
  } eltx_host_t;
endpackage

// >>> core/eltx_if.sv
`timescale 1ns/1ps
interface eltx_if;
  logic       gtx_clk;
  logic       mii_tx_clk;
  logic       tx_en;
  logic       tx_er;
  logic       tx_ctl;
  logic [7:0] txd;
  logic       clk_stop_cap;

  modport phy (input gtx_clk, tx_en, tx_er, tx_ctl, txd, output mii_tx_clk, clk_stop_cap);
  modport mac (output gtx_clk, tx_en, tx_er, tx_ctl, txd, input mii_tx_clk, clk_stop_cap);
endinterface

// >>> core/eltx_phy_tx.sv
`timescale 1ns/1ps
// Functional notes
// - Advertise bits 2/1 apply after restart
// - Strap sets power-up EEE default
// - Wake from LPI within speed limit
// - Transmit and receive LPI kept separate
// - Refresh bursts between quiet periods
// - Optional one-second wait after link up
// - GMII LPI code enters transmit LPI
// - MII LPI code enters transmit LPI
// - Stay while held, leave on change
// - MAC may stop clock after nine
// - MII transmit clock keeps running
// - RGMII 1G: both edges, two nibbles
// - RGMII 1G LPI code enters LPI
// - RGMII 1G exit on any change
// - RGMII 100: ctl both edges, nibble rise
// - RGMII 100 LPI code held
// - RGMII MAC stops clock, pins low
// - Restart bit clears itself
module eltx_phy_tx
  import eltx_pkg::*;
#(
  parameter int WAIT_CYC     = LINKUP_WAIT_CYC,
  parameter int WAKE100_CYC  = WAKE_100_CYC,
  parameter int QUIET_CYCLES = QUIET_CYC,
  parameter int REFR_CYCLES  = REFRESH_CYC
) (
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  eltx_if.phy             link,
  input  wire eltx_mode_t mode,
  input  wire logic       eee_strap,
  input  wire logic       link_up,
  input  wire logic       rx_lpi,
  input  wire logic       mgmt_wr,
  input  wire logic       mgmt_rd,
  input  wire logic [7:0] mgmt_addr,
  input  wire logic [15:0] mgmt_wdata,
  output logic [15:0]     mgmt_rdata,
  output logic            tx_lpi,
  output logic            line_quiet,
  output logic            line_refresh,
  output logic            line_waking,
  output logic            dec_valid,
  output logic            dec_en,
  output logic            dec_er,
  output logic [7:0]      dec_data
);
  logic [11:0] s1_q, s2_q;
  logic        clk_prev_q, mii_clk_q;
  logic [7:0]  div_q;
  logic        strap_done_q, restart_q, wait_en_q, tx_lpi_q;
  logic [15:0] adv_q;
  logic [2:1]  act_q;
  logic [27:0] wait_q;
  logic [23:0] tmr_q;
  logic [3:0]  lo_q;
  logic        en_r_q, vld_q, en_q, er_q;
  logic [7:0]  d_q;
  eltx_line_t  line_q;

  logic s_clk, s_en, s_er, s_ctl, rise, fall, spd1g, is_rgmii, waited, eee_ok, match;
  logic [7:0] s_d;
  logic [23:0] wake_lim;

  // Pins pass two flops; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 12'h000;
      s2_q <= 12'h000;
      clk_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.gtx_clk, link.tx_en, link.tx_er, link.tx_ctl, link.txd};
      s2_q <= s1_q;
      clk_prev_q <= s2_q[11];
    end
  end

  assign s_clk    = s2_q[11];
  assign s_en     = s2_q[10];
  assign s_er     = s2_q[9];
  assign s_ctl    = s2_q[8];
  assign s_d      = s2_q[7:0];
  assign spd1g    = (mode == ELTX_GMII) || (mode == ELTX_RGMII_1G);
  assign is_rgmii = (mode == ELTX_RGMII_1G) || (mode == ELTX_RGMII_100);

  // MII clock is ours and never stops, LPI or not
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      mii_clk_q <= 1'b0;
    end else if (div_q == 8'(LINK_HALF_CYC - 1)) begin
      div_q <= 8'h00;
      mii_clk_q <= ~mii_clk_q;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
  assign link.mii_tx_clk   = mii_clk_q;
  assign link.clk_stop_cap = 1'b1;  // MAC may stop its clock after the LPI hold

  // Edges of whichever clock carries the transmit pins
  always_comb begin
    if (mode == ELTX_MII) begin
      rise = (div_q == 8'(LINK_HALF_CYC - 1)) && !mii_clk_q;
      fall = 1'b0;
    end else begin
      rise = s_clk && !clk_prev_q;
      fall = !s_clk && clk_prev_q;
    end
  end

  // Decode one transfer: single edge for GMII/MII, rise plus fall for RGMII
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_q <= 4'h0;
      en_r_q <= 1'b0;
      vld_q <= 1'b0;
      en_q <= 1'b0;
      er_q <= 1'b0;
      d_q <= 8'h00;
    end else begin
      vld_q <= 1'b0;
      if (is_rgmii) begin
        if (rise) begin
          en_r_q <= s_ctl;            // ctl on rise is enable
          lo_q <= s_d[3:0];
        end
        if (fall) begin
          en_q <= en_r_q;
          er_q <= s_ctl;              // ctl on fall is error
          d_q <= (mode == ELTX_RGMII_1G) ? {s_d[3:0], lo_q} : {4'h0, lo_q};
          vld_q <= 1'b1;
        end
      end else if (rise) begin
        en_q <= s_en;
        er_q <= s_er;
        d_q <= (mode == ELTX_MII) ? {4'h0, s_d[3:0]} : s_d;
        vld_q <= 1'b1;
      end
    end
  end

  // Same code fits every mode once the high nibble is zero-filled
  assign match = !en_q && er_q && (d_q == LPI_DATA);

  // Strap caught after reset release, then software owns the bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_q <= 1'b0;
      adv_q <= 16'h0000;
      act_q <= 2'h0;
      restart_q <= 1'b0;
      wait_en_q <= WAIT_EN_RST;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        adv_q[ADV_1000_BIT] <= eee_strap;
        adv_q[ADV_100_BIT] <= eee_strap;
        act_q <= {eee_strap, eee_strap};
      end else if (mgmt_wr && mgmt_addr == ADV_OFS) begin
        adv_q <= mgmt_wdata;
      end
      if (restart_q) begin
        act_q <= adv_q[ADV_1000_BIT:ADV_100_BIT];
      end
      // A fresh write of one beats the self-clear
      if (mgmt_wr && mgmt_addr == BASIC_CTRL_OFS) begin
        restart_q <= mgmt_wdata[RESTART_AN_BIT];
      end else begin
        restart_q <= 1'b0;
      end
      if (mgmt_wr && mgmt_addr == WAIT_CFG_OFS) begin
        wait_en_q <= mgmt_wdata[WAIT_EN_BIT];
      end
    end
  end

  // Read data is registered one cycle after the strobe
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata <= 16'h0000;
    end else if (mgmt_rd) begin
      case (mgmt_addr)
        BASIC_CTRL_OFS: mgmt_rdata <= 16'(32'(restart_q) << RESTART_AN_BIT);
        ADV_OFS:        mgmt_rdata <= adv_q;
        WAIT_CFG_OFS:   mgmt_rdata <= 16'(32'(wait_en_q) << WAIT_EN_BIT);
        DEV_STAT_OFS:   mgmt_rdata <= {10'h000, act_q, waited, link.clk_stop_cap, rx_lpi, tx_lpi_q};
        default:        mgmt_rdata <= 16'h0000;
      endcase
    end
  end

  // One second of link before LPI, unless the wait is disabled
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 28'h0000000;
    end else if (!link_up) begin
      wait_q <= 28'h0000000;
    end else if (wait_q != 28'(WAIT_CYC)) begin
      wait_q <= wait_q + 28'h0000001;
    end
  end
  assign waited = (wait_q == 28'(WAIT_CYC)) || !wait_en_q;
  assign eee_ok = link_up && waited && (spd1g ? act_q[ADV_1000_BIT] : act_q[ADV_100_BIT]);

  // Transmit LPI; receive LPI is an independent input
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lpi_q <= 1'b0;
    end else if (!eee_ok) begin
      tx_lpi_q <= 1'b0;
    end else if (vld_q) begin
      tx_lpi_q <= match;
    end
  end

  assign wake_lim = spd1g ? 24'(WAKE_1000_CYC) : 24'(WAKE100_CYC);

  // Line side: quiet, refresh, and a bounded wake on exit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_q <= LN_ACTIVE;
      tmr_q <= 24'h000000;
    end else begin
      tmr_q <= tmr_q + 24'h000001;
      case (line_q)
        LN_ACTIVE: begin
          tmr_q <= 24'h000000;
          if (tx_lpi_q) line_q <= LN_QUIET;
        end
        LN_QUIET: begin
          if (!tx_lpi_q) begin
            line_q <= LN_WAKE;
            tmr_q <= 24'h000000;
          end else if (tmr_q == 24'(QUIET_CYCLES - 1)) begin
            line_q <= LN_REFRESH;
            tmr_q <= 24'h000000;
          end
        end
        LN_REFRESH: begin
          if (!tx_lpi_q) begin
            line_q <= LN_WAKE;
            tmr_q <= 24'h000000;
          end else if (tmr_q == 24'(REFR_CYCLES - 1)) begin
            line_q <= LN_QUIET;
            tmr_q <= 24'h000000;
          end
        end
        LN_WAKE: begin
          // Ends one cycle short of the limit so wake stays under it
          if (tmr_q >= wake_lim - 24'h000002) line_q <= LN_ACTIVE;
        end
        default: line_q <= LN_ACTIVE;
      endcase
    end
  end

  assign tx_lpi       = tx_lpi_q;
  assign line_quiet   = line_q == LN_QUIET;
  assign line_refresh = line_q == LN_REFRESH;
  assign line_waking  = line_q == LN_WAKE;
  // Decoded stream keeps flowing so no frame is lost across a wake
  assign dec_valid    = vld_q;
  assign dec_en       = en_q;
  assign dec_er       = er_q;
  assign dec_data     = d_q;
endmodule // eltx_phy_tx

// >>> core/eltx_mac_tx.sv
`timescale 1ns/1ps
module eltx_mac_tx
  import eltx_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  eltx_if.mac              link
);
  logic [3:0]  ctrl_q;
  logic [1:0]  ms1_q, ms2_q;
  logic        mclk_prev_q, clk_q, en_q, er_q, ctl_q;
  logic [7:0]  cnt_q, txd_q;
  logic [3:0]  edges_q;
  eltx_host_t  st_q;
  eltx_mode_t  mode;
  logic        req, mapped, upd_rise, upd_fall, edge_rise, lpi_on, cap;

  assign mode   = eltx_mode_t'(ctrl_q[HC_MODE_LO+1:HC_MODE_LO]);
  assign req    = ctrl_q[HC_LPI_REQ];
  assign mapped = (paddr == H_CTRL_OFS) || (paddr == H_STAT_OFS);
  assign pready = 1'b1;  // Zero-wait slave
  assign pslverr = psel && penable && !mapped;

  // Control register written in the access phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 4'h0;
    end else if (psel && penable && pwrite && paddr == H_CTRL_OFS) begin
      ctrl_q <= pwdata[3:0];
    end
  end

  // Read data captured in the setup phase, stable through access
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        H_CTRL_OFS: prdata <= {28'h0000000, ctrl_q};
        H_STAT_OFS: prdata <= {29'h00000000, cap, st_q == HT_STOPPED, lpi_on};
        default:    prdata <= 32'h00000000;
      endcase
    end
  end

  // Device clock and capability pass two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms1_q <= 2'h0;
      ms2_q <= 2'h0;
      mclk_prev_q <= 1'b0;
    end else begin
      ms1_q <= {link.mii_tx_clk, link.clk_stop_cap};
      ms2_q <= ms1_q;
      mclk_prev_q <= ms2_q[1];
    end
  end
  assign cap = ms2_q[0];

  // Own link clock by divider; pins move midway between its edges
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
    end else if (cnt_q == 8'(2 * LINK_HALF_CYC - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  always_comb begin
    if (mode == ELTX_MII) begin
      upd_rise  = !ms2_q[1] && mclk_prev_q;
      upd_fall  = 1'b0;
      edge_rise = ms2_q[1] && !mclk_prev_q;
    end else begin
      upd_rise  = cnt_q == 8'(LINK_HALF_CYC + LINK_QTR_CYC);
      upd_fall  = cnt_q == 8'(LINK_QTR_CYC);
      edge_rise = (cnt_q == 8'h00) && st_q != HT_STOPPED;
    end
  end
  assign lpi_on = st_q != HT_IDLE;

  // LPI hold, optional clock stop, resume with at least one edge of code
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= HT_IDLE;
      edges_q <= 4'h0;
    end else begin
      if (edge_rise && st_q == HT_LPI && edges_q != 4'hf) edges_q <= edges_q + 4'h1;
      case (st_q)
        HT_IDLE: begin
          edges_q <= 4'h0;
          if (req && upd_rise) st_q <= HT_LPI;
        end
        HT_LPI: begin
          if (upd_rise && !req && edges_q != 4'h0) begin
            st_q <= HT_IDLE;
          end else if (upd_rise && req && ctrl_q[HC_STOP_EN] && cap && mode != ELTX_MII &&
                       edges_q > 4'(STOP_MIN_EDGES)) begin
            // One edge over the minimum: the first edge after entry still carries idle pins
            st_q <= HT_STOPPED;
          end
        end
        HT_STOPPED: begin
          edges_q <= 4'h0;
          if (!req && upd_rise) st_q <= HT_LPI;
        end
        default: st_q <= HT_IDLE;
      endcase
    end
  end

  // Pin drive: idle zeros, LPI code, or ctl and data low while stopped in RGMII
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q <= 1'b0;
      en_q <= 1'b0;
      er_q <= 1'b0;
      ctl_q <= 1'b0;
      txd_q <= 8'h00;
    end else begin
      // Phases start only on a half-period boundary, so a mode change never cuts one short
      if (cnt_q == 8'h00) begin
        clk_q <= (mode != ELTX_MII) && st_q != HT_STOPPED;
      end else if (cnt_q == 8'(LINK_HALF_CYC)) begin
        clk_q <= 1'b0;
      end
      // Low while stopped; the restart point puts the code back before the clock runs
      if (st_q == HT_STOPPED && (mode == ELTX_RGMII_1G || mode == ELTX_RGMII_100) && !(upd_rise && !req)) begin
        ctl_q <= 1'b0;
        txd_q <= 8'h00;
      end else if (upd_rise) begin
        en_q <= 1'b0;
        er_q <= lpi_on;
        ctl_q <= 1'b0;
        txd_q <= lpi_on ? LPI_DATA : 8'h00;
      end else if (upd_fall) begin
        ctl_q <= lpi_on;
        if (mode == ELTX_RGMII_1G) txd_q <= {4'h0, LPI_DATA[7:4]};
      end
    end
  end

  assign link.gtx_clk = clk_q;
  assign link.tx_en   = en_q;
  assign link.tx_er   = er_q;
  assign link.tx_ctl  = ctl_q;
  assign link.txd     = txd_q;
endmodule // eltx_mac_tx

// >>> tb/eltx_link_checker.sv
`timescale 1ns/1ps
module eltx_link_checker
  import eltx_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst_n,
  input wire logic       gtx_clk,
  input wire logic       mii_tx_clk,
  input wire logic       tx_en,
  input wire logic       tx_er,
  input wire logic       tx_ctl,
  input wire logic [7:0] txd,
  input wire logic       clk_stop_cap
);
  logic [6:0] low_cnt_q;
  logic [3:0] rise_cnt_q;
  logic       armed_q;
  logic       stopped_q;
  logic       code_w;
  logic       stop_ev;

  // LPI code in GMII/MII form or RGMII rising-edge form
  assign code_w  = (!tx_en && tx_er && txd == LPI_DATA) || (!tx_ctl && txd[3:0] == 4'h1);
  // Only a clock that has run with the code can stop; a hand-over to MII on idle pins does not count
  assign stop_ev = armed_q && low_cnt_q == 7'h15 && !gtx_clk && rise_cnt_q != 4'h0;

  // Low-phase length, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) low_cnt_q <= 7'h0;
    else if (gtx_clk) low_cnt_q <= 7'h0;
    else if (low_cnt_q != 7'h7f) low_cnt_q <= low_cnt_q + 7'h1;
  end

  // Stop tracking
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q   <= 1'b0;
      stopped_q <= 1'b0;
    end else begin
      armed_q   <= armed_q | gtx_clk;
      stopped_q <= gtx_clk ? 1'b0 : (stopped_q | stop_ev);
    end
  end

  // Rising edges seen with the code held
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) rise_cnt_q <= 4'h0;
    else if ($rose(gtx_clk)) rise_cnt_q <= !code_w ? 4'h0 : (rise_cnt_q == 4'hf ? 4'hf : rise_cnt_q + 4'h1);
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_restart;
    stopped_q ##0 gtx_clk;
  endsequence

  property p_half(logic c);
    $changed(c) |=> $stable(c) [*8];
  endproperty

  chk_cap_tied: assert property (clk_stop_cap)
    else $error("stop capability not reported");
  chk_mii_runs: assert property (1'b1 |-> ##[1:24] $changed(mii_tx_clk))
    else $error("mii transmit clock stopped");
  chk_mii_half: assert property (p_half(mii_tx_clk))
    else $error("mii transmit clock phase too short");
  chk_gtx_half: assert property (p_half(gtx_clk))
    else $error("link clock phase too short");
  chk_stop_nine: assert property (stop_ev |-> rise_cnt_q >= 4'd9)
    else $error("clock stopped before nine code edges");
  chk_restart_code: assert property (s_restart |-> code_w)
    else $error("clock restarted without the idle code");
  chk_edge_stable: assert property ($changed(gtx_clk) |-> $stable({tx_en, tx_er, tx_ctl, txd}))
    else $error("pins moved at a link clock edge");
  chk_er_code: assert property ($rose(gtx_clk) && tx_er && !tx_en |-> txd == LPI_DATA)
    else $error("error without idle data");
endmodule // eltx_link_checker

// >>> tb/eee_tx_lpi_control_bench.sv
`timescale 1ns/1ps
module eee_tx_lpi_control_bench;
  import eltx_pkg::*;
  localparam int WAIT_T = 100;
  localparam int QUIET_T = 50;
  localparam int REFR_T = 20;
  localparam int WAKE_T = 40;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  eltx_mode_t mode = ELTX_MII;
  logic eee_strap = 1'b1;
  logic link_up = 1'b0;
  logic rx_lpi = 1'b0;
  logic mgmt_wr = 1'b0;
  logic mgmt_rd = 1'b0;
  logic [7:0] mgmt_addr = 8'h00;
  logic [15:0] mgmt_wdata = 16'h0000;
  logic [15:0] mgmt_rdata, mr;
  logic tx_lpi, line_quiet, line_refresh, line_waking, dec_valid, dec_en, dec_er, c;
  logic [7:0] dec_data;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  int failures = 0;
  int checks_done = 0;
  int n, k, v;

  eltx_if link_a ();

  eltx_phy_tx #(.WAIT_CYC(WAIT_T), .WAKE100_CYC(WAKE_T), .QUIET_CYCLES(QUIET_T), .REFR_CYCLES(REFR_T)) i_eltx_phy_tx (
    .core_clk(core_clk), .rst_n(rst_n), .link(link_a), .mode(mode), .eee_strap(eee_strap),
    .link_up(link_up), .rx_lpi(rx_lpi), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_addr(mgmt_addr),
    .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata), .tx_lpi(tx_lpi), .line_quiet(line_quiet),
    .line_refresh(line_refresh), .line_waking(line_waking), .dec_valid(dec_valid), .dec_en(dec_en),
    .dec_er(dec_er), .dec_data(dec_data));

  eltx_mac_tx i_eltx_mac_tx (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_a));

  eltx_link_checker i_eltx_link_checker (
    .core_clk(core_clk), .rst_n(rst_n), .gtx_clk(link_a.gtx_clk), .mii_tx_clk(link_a.mii_tx_clk),
    .tx_en(link_a.tx_en), .tx_er(link_a.tx_er), .tx_ctl(link_a.tx_ctl), .txd(link_a.txd),
    .clk_stop_cap(link_a.clk_stop_cap));

  // 250 MHz core clock
  always #2 core_clk = ~core_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; holds everything until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready
    do begin @(posedge core_clk); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  // Device management access; read data lands one cycle after the strobe
  task automatic mg(input logic w, input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    mgmt_wr <= w; mgmt_rd <= !w; mgmt_addr <= a; mgmt_wdata <= d;
    @(posedge core_clk);
    mgmt_wr <= 1'b0; mgmt_rd <= 1'b0;
    @(posedge core_clk);
    mr = mgmt_rdata;
  endtask

  // Bounded wait for the transmit state, sampled away from the active edge
  task automatic wt(input logic v, input int lim);
    n = 0;
    while (tx_lpi !== v && n < lim) begin @(negedge core_clk); n++; end
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return line_quiet;
      1: return line_refresh;
      default: return line_waking;
    endcase
  endfunction

  // Length of the next high run of a line state
  task automatic span(input int s);
    n = 0;
    while (pick(s) !== 1'b1 && n < 100) begin @(negedge core_clk); n++; end
    n = 0;
    while (pick(s) === 1'b1 && n < 5000) begin @(negedge core_clk); n++; end
  endtask

  task automatic regs_after_reset();
    mg(0, ADV_OFS, 16'h0); chk("adv strap", mr, 16'h0006);
    mg(0, WAIT_CFG_OFS, 16'h0); chk("wait en", mr[WAIT_EN_BIT], WAIT_EN_RST);
    apb(0, H_STAT_OFS, 32'h0); chk("stat cap", rd[HS_CAP], 1'b1);
    apb(0, 12'h008, 32'h0); chk("unmapped", err, 1'b1);
    // Advertisement alone must not change the active speeds
    mg(1, ADV_OFS, 16'h0002); mg(0, DEV_STAT_OFS, 16'h0);
    chk("before restart", {mr[ST_ACT1G], mr[ST_ACT100]}, 2'b11);
    mg(1, BASIC_CTRL_OFS, 16'h0200); mg(0, BASIC_CTRL_OFS, 16'h0);
    chk("restart clears", mr[RESTART_AN_BIT], 1'b0);
    rx_lpi <= 1'b1; mg(0, DEV_STAT_OFS, 16'h0);
    chk("after restart", {mr[ST_ACT1G], mr[ST_ACT100]}, 2'b01);
    chk("rx only", {mr[ST_RX_LPI], mr[ST_TX_LPI]}, 2'b10);
  endtask

  task automatic mii_lpi();
    mode <= ELTX_MII; link_up <= 1'b0;
    apb(1, H_CTRL_OFS, 32'h3);
    link_up <= 1'b1; wt(1, 2000);
    chk("linkup wait", n >= WAIT_T, 1'b1);
    chk("mii code", {dec_en, dec_er, dec_data[3:0]}, 6'h11);
    span(0); chk("quiet", n >= QUIET_T - 1 && n <= QUIET_T + 1, 1'b1);
    span(1); chk("refresh", n, REFR_T);
    k = 0; v = 0; c = link_a.mii_tx_clk;
    repeat (100) begin
      @(negedge core_clk);
      if (link_a.mii_tx_clk !== c) k++;
      if (dec_valid === 1'b1) v++;
      c = link_a.mii_tx_clk;
    end
    chk("mii clk runs", k, 5);
    chk("dec pulses", v >= 2 && v <= 3, 1'b1);
    apb(1, H_CTRL_OFS, 32'h2); wt(0, 300); chk("mii exit", tx_lpi, 1'b0);
    span(2); chk("wake 100", n, WAKE_T - 1);
  endtask

  task automatic gmii_lpi();
    // 1G not advertised yet: the code is decoded but refused
    @(posedge core_clk);
    mode <= ELTX_GMII; apb(1, H_CTRL_OFS, 32'h9);
    repeat (600) @(negedge core_clk);
    chk("1g off", tx_lpi, 1'b0);
    chk("gmii code", {dec_en, dec_er, dec_data}, 10'h101);
    apb(1, H_CTRL_OFS, 32'h0); repeat (100) @(negedge core_clk);
    mg(1, ADV_OFS, 16'h0006); mg(1, BASIC_CTRL_OFS, 16'h0200);
    apb(1, H_CTRL_OFS, 32'h9); wt(1, 300); chk("gmii enter", tx_lpi, 1'b1);
    repeat (500) @(negedge core_clk);
    apb(0, H_STAT_OFS, 32'h0); chk("stopped", rd[HS_STOPPED:HS_LPI], 2'b11);
    chk("held stopped", tx_lpi, 1'b1);
    apb(1, H_CTRL_OFS, 32'h8); wt(0, 300); chk("gmii exit", tx_lpi, 1'b0);
    span(2); chk("wake 1g", n, WAKE_1000_CYC - 1);
  endtask

  task automatic rgmii_lpi();
    @(posedge core_clk);
    mode <= ELTX_RGMII_1G; apb(1, H_CTRL_OFS, 32'hd);
    wt(1, 300); chk("rgmii enter", tx_lpi, 1'b1);
    chk("rgmii code", {dec_en, dec_er, dec_data}, 10'h101);
    repeat (500) @(negedge core_clk);
    chk("pins low", {link_a.tx_ctl, link_a.txd[3:0]}, 5'h0);
    apb(1, H_CTRL_OFS, 32'hc); wt(0, 300); chk("rgmii exit", tx_lpi, 1'b0);
    @(posedge core_clk);
    mode <= ELTX_RGMII_100; apb(1, H_CTRL_OFS, 32'h7);
    wt(1, 300); chk("r100 enter", tx_lpi, 1'b1);
    chk("r100 data", dec_data, LPI_DATA);
    apb(1, H_CTRL_OFS, 32'h6); wt(0, 300); chk("r100 exit", tx_lpi, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    link_up <= 1'b1;
    repeat (3) @(posedge core_clk);
    regs_after_reset();
    mii_lpi();
    gmii_lpi();
    rgmii_lpi();
    report_and_stop();
  end

  // Watchdog about three times the expected run of some seven thousand cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end
endmodule // eee_tx_lpi_control_bench
